//--- hw/fpt_flash_ctrl.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Erase clears a whole 1-KB block to ones
// - Program one word, only ones become zeros
// - Protection granule is a 2-KB block pair
// - Two 32-bit policy registers, one bit each
// - Program-enable one allows program and erase
// - Read-enable zero permits execution only
// - Execute-only admits instruction fetch alone
// - Program one, read zero: write, no read
// - Read-only blocks refuse writes; both ones open
// - Refused data read returns a bus fault
// - Refused write raises access flag, masked irq
// - Factory state: every protection bit one
// - Protection bits only clear, never set
// - Uncommitted clears undone by power-on reset
// - Control register commit bit saves policy bits
// - Timing from cycles-per-microsecond register
// - Reset loads reload value for max clock
// - Address bit 0 picks which policy commits
// - Write one clears raw and masked flags
module fpt_flash_ctrl
  import fpt_pkg::*;
#(
  parameter logic [15:0] PROG_US = PROG_TIME_US,
  parameter logic [15:0] ERASE_US = ERASE_TIME_US
) (
  // Clock and resets
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  input wire logic factory_nrst_in,
  // Register port
  input wire logic [7:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  // Flash read port
  input wire logic [15:0] mem_addr_in,
  input wire logic mem_fetch_in,
  input wire logic mem_data_rd_in,
  input wire logic mem_debug_rd_in,
  output logic mem_stall_out,
  output logic [31:0] mem_rdata_out,
  output logic mem_fault_out,
  // Interrupt
  output logic flash_irq_out
);
  fpt_state_type state_r;
  fpt_op_type op_r;
  logic [31:0] flash_r [FLASH_WORDS];
  logic [31:0] flash_address_reg_r;
  logic [31:0] flash_data_r;
  logic [31:0] block_program_enable_bits_r;
  logic [31:0] block_read_enable_bits_r;
  logic [31:0] nv_program_enable_r;
  logic [31:0] nv_read_enable_r;
  logic [7:0] microsecond_reload_reg_r;
  logic [7:0] prescale_r;
  logic [15:0] us_left_r;
  logic [1:0] raw_irq_r;
  logic [1:0] flash_irq_mask_reg_r;
  logic [31:0] reg_rdata_r;
  logic [31:0] mem_rdata_r;
  logic mem_fault_r;
  logic sel_pe_r;
  logic [WORD_AW-1:0] op_word;
  logic [4:0] op_prot;
  logic [4:0] rd_prot;
  logic ctl_wr;
  logic ctl_key_ok;
  logic want_prog;
  logic want_erase;
  logic want_commit;
  logic op_allowed;
  logic us_tick;
  logic op_done;
  logic [1:0] ris_set;
  logic [1:0] ris_clr;

  assign op_word = flash_address_reg_r[WORD_AW+1:2];
  assign op_prot = op_word[WORD_AW-1:PROT_SHIFT];
  assign rd_prot = mem_addr_in[15:11];
  assign ctl_wr = reg_wr_in && reg_addr_in == ADDR_CTRL && state_r == FPT_IDLE;
  assign ctl_key_ok = reg_wdata_in[31:CTRL_KEY_LSB] == CTRL_KEY;
  assign want_prog = ctl_wr && ctl_key_ok && reg_wdata_in[CTRL_WRITE_BIT];
  assign want_erase = ctl_wr && ctl_key_ok && reg_wdata_in[CTRL_ERASE_BIT]
                      && !reg_wdata_in[CTRL_WRITE_BIT];
  assign want_commit = ctl_wr && reg_wdata_in[CTRL_COMMIT_BIT] && !want_prog && !want_erase;
  // Write permission from the live (possibly uncommitted) bits
  assign op_allowed = block_program_enable_bits_r[op_prot];
  assign us_tick = prescale_r == microsecond_reload_reg_r;
  assign op_done = state_r == FPT_BUSY && us_tick && us_left_r == 16'h0001;
  // Reads are held off for the length of any flash operation
  assign mem_stall_out = state_r != FPT_IDLE;

  // Sequencer: one cycle to load policy from nonvolatile copy, then ops
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_r <= FPT_LOAD;
      op_r <= FPT_OP_PROG;
      us_left_r <= 16'h0000;
      prescale_r <= 8'h00;
      sel_pe_r <= 1'b0;
    end else begin
      case (state_r)
        FPT_LOAD: state_r <= FPT_IDLE;
        FPT_IDLE: begin
          prescale_r <= 8'h00;
          if ((want_prog || want_erase) && op_allowed) begin
            state_r <= FPT_BUSY;
            op_r <= want_prog ? FPT_OP_PROG : FPT_OP_ERASE;
            us_left_r <= want_prog ? PROG_US : ERASE_US;
          end else if (want_commit) begin
            state_r <= FPT_BUSY;
            op_r <= FPT_OP_COMMIT;
            us_left_r <= COMMIT_TIME_US;
            sel_pe_r <= flash_address_reg_r[TARGET_SEL_PE_BIT];
          end
        end
        FPT_BUSY: begin
          prescale_r <= us_tick ? 8'h00 : prescale_r + 8'h01;
          if (us_tick) begin
            us_left_r <= us_left_r - 16'h0001;
          end
          if (op_done) begin
            state_r <= FPT_IDLE;
          end
        end
        default: state_r <= FPT_IDLE;
      endcase
    end
  end

  // Array contents survive power-on reset; only factory reset erases
  always_ff @(posedge clk_sys_in or negedge factory_nrst_in) begin
    if (!factory_nrst_in) begin
      for (int i = 0; i < FLASH_WORDS; i++) begin
        flash_r[i] <= ERASED_WORD;
      end
    end else if (op_done && op_r == FPT_OP_PROG) begin
      flash_r[op_word] <= flash_r[op_word] & flash_data_r;
    end else if (op_done && op_r == FPT_OP_ERASE) begin
      for (int i = 0; i < ERASE_WORDS; i++) begin
        flash_r[{op_word[WORD_AW-1:ERASE_SHIFT], 8'(i)}] <= ERASED_WORD;
      end
    end
  end

  // Committed policy, also immune to power-on reset
  always_ff @(posedge clk_sys_in or negedge factory_nrst_in) begin
    if (!factory_nrst_in) begin
      nv_program_enable_r <= PROT_FACTORY;
      nv_read_enable_r <= PROT_FACTORY;
    end else if (op_done && op_r == FPT_OP_COMMIT) begin
      if (sel_pe_r) begin
        nv_program_enable_r <= nv_program_enable_r & block_program_enable_bits_r;
      end else begin
        nv_read_enable_r <= nv_read_enable_r & block_read_enable_bits_r;
      end
    end
  end

  // Live policy bits: reloaded from committed copy, software may only clear
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      block_program_enable_bits_r <= PROT_FACTORY;
      block_read_enable_bits_r <= PROT_FACTORY;
    end else if (state_r == FPT_LOAD) begin
      block_program_enable_bits_r <= nv_program_enable_r;
      block_read_enable_bits_r <= nv_read_enable_r;
    end else if (reg_wr_in && reg_addr_in == ADDR_PE) begin
      block_program_enable_bits_r <= block_program_enable_bits_r & reg_wdata_in;
    end else if (reg_wr_in && reg_addr_in == ADDR_RE) begin
      block_read_enable_bits_r <= block_read_enable_bits_r & reg_wdata_in;
    end
  end

  // Plain software registers
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      flash_address_reg_r <= 32'h00000000;
      flash_data_r <= 32'h00000000;
      flash_irq_mask_reg_r <= 2'h0;
      microsecond_reload_reg_r <= USEC_RESET;
    end else if (reg_wr_in) begin
      case (reg_addr_in)
        // Target and data held while busy, else a late write dodges protection
        ADDR_TARGET: begin
          if (state_r != FPT_BUSY) begin
            flash_address_reg_r <= {16'h0000, reg_wdata_in[15:0]};
          end
        end
        ADDR_FMD: begin
          if (state_r != FPT_BUSY) begin
            flash_data_r <= reg_wdata_in;
          end
        end
        ADDR_IM: flash_irq_mask_reg_r <= reg_wdata_in[1:0];
        ADDR_USEC: microsecond_reload_reg_r <= reg_wdata_in[7:0];
        default: flash_address_reg_r <= flash_address_reg_r;
      endcase
    end
  end

  // Raw flags: a new event wins over a same-cycle clear
  always_comb begin
    ris_set = 2'h0;
    ris_set[IRQ_ACCESS_BIT] = (want_prog || want_erase) && !op_allowed;
    ris_set[IRQ_PROG_BIT] = op_done && op_r != FPT_OP_COMMIT;
    ris_clr = (reg_wr_in && reg_addr_in == ADDR_MISC) ? reg_wdata_in[1:0] : 2'h0;
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      raw_irq_r <= 2'h0;
    end else begin
      raw_irq_r <= (raw_irq_r & ~ris_clr) | ris_set;
    end
  end

  assign flash_irq_out = |(raw_irq_r & flash_irq_mask_reg_r);

  // Register read data, valid the cycle after the strobe
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      reg_rdata_r <= 32'h00000000;
    end else if (reg_rd_in) begin
      case (reg_addr_in)
        ADDR_TARGET: reg_rdata_r <= flash_address_reg_r;
        ADDR_FMD: reg_rdata_r <= flash_data_r;
        ADDR_CTRL: reg_rdata_r <= {28'h0000000, state_r == FPT_BUSY && op_r == FPT_OP_COMMIT,
                                  1'b0, state_r == FPT_BUSY && op_r == FPT_OP_ERASE,
                                  state_r == FPT_BUSY && op_r == FPT_OP_PROG};
        ADDR_RIS: reg_rdata_r <= {30'h00000000, raw_irq_r};
        ADDR_IM: reg_rdata_r <= {30'h00000000, flash_irq_mask_reg_r};
        ADDR_MISC: reg_rdata_r <= {30'h00000000, raw_irq_r & flash_irq_mask_reg_r};
        ADDR_USEC: reg_rdata_r <= {24'h000000, microsecond_reload_reg_r};
        ADDR_RE: reg_rdata_r <= block_read_enable_bits_r;
        ADDR_PE: reg_rdata_r <= block_program_enable_bits_r;
        default: reg_rdata_r <= 32'h00000000;
      endcase
    end else begin
      reg_rdata_r <= 32'h00000000;
    end
  end
  assign reg_rdata_out = reg_rdata_r;

  // Flash reads: fetch always admitted, data and debug reads need read enable
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      mem_rdata_r <= 32'h00000000;
      mem_fault_r <= 1'b0;
    end else begin
      mem_fault_r <= 1'b0;
      mem_rdata_r <= 32'h00000000;
      if (!mem_stall_out && mem_fetch_in) begin
        mem_rdata_r <= flash_r[mem_addr_in[15:2]];
      end else if (!mem_stall_out && (mem_data_rd_in || mem_debug_rd_in)) begin
        if (block_read_enable_bits_r[rd_prot]) begin
          mem_rdata_r <= flash_r[mem_addr_in[15:2]];
        end else begin
          mem_fault_r <= 1'b1;
        end
      end
    end
  end
  assign mem_rdata_out = mem_rdata_r;
  assign mem_fault_out = mem_fault_r;

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!nrst_in);

  sequence s_denied_cmd;
    (want_prog || want_erase) && !op_allowed;
  endsequence
  sequence s_blocked_read;
    !mem_stall_out && !mem_fetch_in && mem_data_rd_in && !block_read_enable_bits_r[rd_prot];
  endsequence

  property p_denied_no_start;
    s_denied_cmd |=> state_r == FPT_IDLE && raw_irq_r[IRQ_ACCESS_BIT];
  endproperty
  a_denied_no_start: assert property (p_denied_no_start)
    else $error("refused write started or missed flag");
  property p_read_fault;
    s_blocked_read |=> mem_fault_out && mem_rdata_out == 32'h00000000;
  endproperty
  a_read_fault: assert property (p_read_fault)
    else $error("blocked data read gave no fault");
  property p_fetch_ok;
    !mem_stall_out && mem_fetch_in |=> !mem_fault_out;
  endproperty
  a_fetch_ok: assert property (p_fetch_ok)
    else $error("instruction fetch faulted");
  property p_pe_clear_only;
    $past(state_r) != FPT_LOAD |-> (block_program_enable_bits_r
      & ~$past(block_program_enable_bits_r)) == 32'h00000000;
  endproperty
  a_pe_clear_only: assert property (p_pe_clear_only)
    else $error("program enable bit was set");
  property p_nv_clear_only;
    (nv_read_enable_r & ~$past(nv_read_enable_r)) == 32'h00000000;
  endproperty
  a_nv_clear_only: assert property (p_nv_clear_only)
    else $error("committed read enable bit rose");
  property p_irq_masked;
    (want_prog || want_erase) && !op_allowed && flash_irq_mask_reg_r[IRQ_ACCESS_BIT]
      |=> flash_irq_out;
  endproperty
  a_irq_masked: assert property (p_irq_masked)
    else $error("interrupt output disagrees with mask");
  property p_flag_clear;
    reg_wr_in && reg_addr_in == ADDR_MISC && reg_wdata_in[IRQ_ACCESS_BIT]
      && !ris_set[IRQ_ACCESS_BIT] |=> !raw_irq_r[IRQ_ACCESS_BIT];
  endproperty
  a_flag_clear: assert property (p_flag_clear)
    else $error("access flag not cleared");
  property p_denied_intact;
    s_denied_cmd |=> block_program_enable_bits_r == $past(block_program_enable_bits_r)
      && flash_r[$past(op_word)] == $past(flash_r[op_word]);
  endproperty
  a_denied_intact: assert property (p_denied_intact)
    else $error("refused write altered flash or policy");
  property p_tick_span;
    state_r == FPT_BUSY && us_tick && microsecond_reload_reg_r == 8'h01 && !op_done
      |=> !us_tick ##1 us_tick;
  endproperty
  a_tick_span: assert property (p_tick_span)
    else $error("microsecond tick spacing wrong");
endmodule

//--- hw/fpt_pkg.sv
package fpt_pkg;
  // Register byte addresses on the plain register port
  localparam logic [7:0] ADDR_TARGET = 8'h00;
  localparam logic [7:0] ADDR_FMD = 8'h04;
  localparam logic [7:0] ADDR_CTRL = 8'h08;
  localparam logic [7:0] ADDR_RIS = 8'h0c;
  localparam logic [7:0] ADDR_IM = 8'h10;
  localparam logic [7:0] ADDR_MISC = 8'h14;
  localparam logic [7:0] ADDR_USEC = 8'h18;
  localparam logic [7:0] ADDR_RE = 8'h1c;
  localparam logic [7:0] ADDR_PE = 8'h20;
  // Control register fields
  localparam logic [15:0] CTRL_KEY = 16'ha442;
  localparam int CTRL_KEY_LSB = 16;
  localparam int CTRL_WRITE_BIT = 0;
  localparam int CTRL_ERASE_BIT = 1;
  localparam int CTRL_COMMIT_BIT = 3;
  localparam int TARGET_SEL_PE_BIT = 0;
  // Interrupt flag / mask positions
  localparam int IRQ_ACCESS_BIT = 0;
  localparam int IRQ_PROG_BIT = 1;
  // Geometry: 64 KB array, 1 KB erase, 2 KB protection blocks
  localparam int FLASH_WORDS = 16384;
  localparam int WORD_AW = 14;
  localparam int ERASE_WORDS = 256;
  localparam int ERASE_SHIFT = 8;
  localparam int PROT_SHIFT = 9;
  localparam int PROT_BLOCKS = 32;
  localparam logic [31:0] PROT_FACTORY = 32'hffffffff;
  localparam logic [31:0] ERASED_WORD = 32'hffffffff;
  // Timing
  localparam int CLK_MHZ = 20;
  localparam logic [7:0] USEC_RESET = 8'(CLK_MHZ - 1);
  localparam logic [15:0] PROG_TIME_US = 16'h0014;
  localparam logic [15:0] ERASE_TIME_US = 16'h00c8;
  localparam logic [15:0] COMMIT_TIME_US = 16'h0014;
  typedef enum logic [1:0] {FPT_LOAD, FPT_IDLE, FPT_BUSY} fpt_state_type;
  typedef enum logic [1:0] {FPT_OP_PROG, FPT_OP_ERASE, FPT_OP_COMMIT} fpt_op_type;
endpackage

//--- tb/test_flash_protection_timing.sv
`timescale 1ns/1ps
module test_flash_protection_timing;
  import fpt_pkg::*;
  logic clk_sys_in = 1'b0;
  logic nrst_in = 1'b0;
  logic factory_nrst_in = 1'b0;
  logic [7:0] reg_addr_in = 8'h00;
  logic [31:0] reg_wdata_in = 32'h00000000;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic [31:0] reg_rdata_out;
  logic [15:0] mem_addr_in = 16'h0000;
  logic mem_fetch_in = 1'b0;
  logic mem_data_rd_in = 1'b0;
  logic mem_debug_rd_in = 1'b0;
  logic mem_stall_out;
  logic [31:0] mem_rdata_out;
  logic mem_fault_out;
  logic flash_irq_out;
  int n_mismatch = 0;
  int samples_checked = 0;
  logic [31:0] seed = 32'h5193;
  logic [31:0] model [int];
  logic [31:0] v;
  logic f;
  int w;

  localparam int TB_OP_US = 8;

  // Short program and erase times keep polling loops brief
  fpt_flash_ctrl #(.PROG_US(16'(TB_OP_US)), .ERASE_US(16'h0008)) i_dut (
    .clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .factory_nrst_in(factory_nrst_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .mem_addr_in(mem_addr_in),
    .mem_fetch_in(mem_fetch_in), .mem_data_rd_in(mem_data_rd_in),
    .mem_debug_rd_in(mem_debug_rd_in), .mem_stall_out(mem_stall_out),
    .mem_rdata_out(mem_rdata_out), .mem_fault_out(mem_fault_out),
    .flash_irq_out(flash_irq_out));

  always #25 clk_sys_in = ~clk_sys_in;

  function automatic logic [31:0] lfsr_next(input logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h80200003 : 32'h00000000);
  endfunction

  function automatic logic [31:0] prog_expect(input logic [31:0] old, input logic [31:0] d);
    return old & d;
  endfunction

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge clk_sys_in);
    reg_wr_in <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge clk_sys_in);
    reg_rd_in <= 1'b0;
    #1 d = reg_rdata_out;
  endtask

  // Kind 0 fetch, 1 data read, 2 debug read
  task automatic mrd(input int kind, input logic [15:0] a, output logic [31:0] d,
                     output logic flt);
    @(posedge clk_sys_in);
    mem_addr_in <= a;
    mem_fetch_in <= (kind == 0);
    mem_data_rd_in <= (kind == 1);
    mem_debug_rd_in <= (kind == 2);
    @(posedge clk_sys_in);
    mem_fetch_in <= 1'b0;
    mem_data_rd_in <= 1'b0;
    mem_debug_rd_in <= 1'b0;
    #1 d = mem_rdata_out;
    flt = mem_fault_out;
  endtask

  task automatic wait_idle();
    logic [31:0] s;
    int n;
    n = 0;
    rd(ADDR_CTRL, s);
    while (s !== 32'h00000000 && n < 200) begin
      rd(ADDR_CTRL, s);
      n++;
    end
    chk("control idle", 32'h00000000, s);
    chk("stall after op", 32'h0, {31'h0, mem_stall_out});
  endtask

  task automatic flash_op(input logic [15:0] a, input logic [31:0] d, input logic erase);
    wr(ADDR_FMD, d);
    wr(ADDR_TARGET, {16'h0000, a});
    wr(ADDR_CTRL, {CTRL_KEY, 14'h0000, erase, ~erase});
  endtask

  // Busy span must be (reload + 1) cycles for each microsecond of programming
  task automatic timed_prog(input logic [7:0] rl, input int wi, input logic [31:0] d);
    int n;
    n = 0;
    wr(ADDR_USEC, {24'h000000, rl});
    if (!model.exists(wi)) model[wi] = ERASED_WORD;
    model[wi] = prog_expect(model[wi], d);
    flash_op(16'(wi * 4), d, 1'b0);
    #1;
    while (mem_stall_out === 1'b1 && n < 1000) begin
      n++;
      @(posedge clk_sys_in);
      #1;
    end
    chk("busy cycles", 32'((int'(rl) + 1) * TB_OP_US), 32'(n));
    wr(ADDR_MISC, 32'h00000002);
  endtask

  task automatic do_reset(input logic factory);
    @(posedge clk_sys_in);
    nrst_in <= 1'b0;
    factory_nrst_in <= ~factory;
    #1 chk("stall in reset", 32'h1, {31'h0, mem_stall_out});
    repeat (10) @(posedge clk_sys_in);
    nrst_in <= 1'b1;
    factory_nrst_in <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
  endtask

  task automatic give_verdict();
    if (n_mismatch == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys_in);
    n_mismatch++;
    give_verdict();
  end

  initial begin
    do_reset(1'b1);
    rd(ADDR_USEC, v); chk("reload reset", {24'h0, USEC_RESET}, v);
    rd(ADDR_RE, v); chk("read enables", PROT_FACTORY, v);
    rd(ADDR_PE, v); chk("program enables", PROT_FACTORY, v);
    rd(8'h40, v); chk("unmapped read", 32'h00000000, v);
    seed = lfsr_next(seed);
    timed_prog(USEC_RESET, 8, seed);
    seed = lfsr_next(seed);
    timed_prog(8'h01, 9, seed);
    // Fastest timing for the remaining operations
    wr(ADDR_USEC, 32'h00000000);
    // Random word programs in page 0, some twice to see ANDing
    for (int i = 0; i < 8; i++) begin
      seed = lfsr_next(seed);
      w = (i == 7) ? 3 : int'(seed[7:0] & 8'h07);
      seed = lfsr_next(seed);
      if (!model.exists(w)) model[w] = ERASED_WORD;
      model[w] = prog_expect(model[w], seed);
      flash_op(16'(w * 4), seed, 1'b0);
      if (i == 0) begin
        rd(ADDR_CTRL, v); chk("busy write bit", 32'h1, v & 32'h1);
      end
      wait_idle();
      rd(ADDR_RIS, v); chk("done flag", 32'h2, v & 32'h2);
      wr(ADDR_MISC, 32'h00000002);
    end
    foreach (model[k]) begin
      mrd(0, 16'(k * 4), v, f); chk("programmed word", model[k], v);
    end
    flash_op(16'h0400, 32'h5a5a0f0f, 1'b0); wait_idle();
    flash_op(16'h0000, 32'h0, 1'b1); wait_idle();
    foreach (model[k]) begin
      mrd(0, 16'(k * 4), v, f); chk("erased word", ERASED_WORD, v);
    end
    mrd(1, 16'h0400, v, f); chk("next page kept", 32'h5a5a0f0f, v);
    flash_op(16'h0800, 32'h0f0f5a5a, 1'b0); wait_idle();
    // Protection: block1 read-only, block2 execute-only, block3 write-only
    wr(ADDR_PE, 32'hfffffff9);
    wr(ADDR_RE, 32'hfffffff3);
    wr(ADDR_PE, 32'hffffffff);
    wr(ADDR_RE, 32'hffffffff);
    rd(ADDR_PE, v); chk("pe sticky", 32'hfffffff9, v);
    rd(ADDR_RE, v); chk("re sticky", 32'hfffffff3, v);
    wr(ADDR_IM, 32'h00000000);
    flash_op(16'h0800, 32'h00000000, 1'b1);
    rd(ADDR_CTRL, v); chk("refused not busy", 32'h0, v);
    rd(ADDR_RIS, v); chk("access flag", 32'h1, v & 32'h1);
    chk("irq masked", 32'h0, {31'h0, flash_irq_out});
    wr(ADDR_MISC, 32'h00000001);
    rd(ADDR_RIS, v); chk("access cleared", 32'h0, v & 32'h1);
    wr(ADDR_IM, 32'h00000001);
    flash_op(16'h1000, 32'h0, 1'b0);
    rd(ADDR_MISC, v); chk("masked status", 32'h1, v & 32'h1);
    chk("irq raised", 32'h1, {31'h0, flash_irq_out});
    wr(ADDR_MISC, 32'h00000001);
    #1 chk("irq cleared", 32'h0, {31'h0, flash_irq_out});
    mrd(1, 16'h0800, v, f); chk("read-only data", 32'h0f0f5a5a, v);
    chk("read-only no fault", 32'h0, {31'h0, f});
    mrd(0, 16'h1000, v, f); chk("exec-only fetch fault", 32'h0, {31'h0, f});
    chk("exec-only kept", ERASED_WORD, v);
    mrd(1, 16'h1000, v, f); chk("exec-only data fault", 32'h1, {31'h0, f});
    chk("faulted data zero", 32'h0, v);
    mrd(2, 16'h1004, v, f); chk("debug read fault", 32'h1, {31'h0, f});
    flash_op(16'h1800, 32'h12345678, 1'b0); wait_idle();
    mrd(0, 16'h1800, v, f); chk("write-only fetch", 32'h12345678, v);
    mrd(1, 16'h1800, v, f); chk("write-only data fault", 32'h1, {31'h0, f});
    mrd(1, 16'h1ffc, v, f); chk("block edge fault", 32'h1, {31'h0, f});
    mrd(1, 16'h2000, v, f); chk("next block open", 32'h0, {31'h0, f});
    // Commit read enables only, then power-on reset
    wr(ADDR_TARGET, 32'h00000000);
    wr(ADDR_CTRL, 32'h00000008);
    wait_idle();
    do_reset(1'b0);
    rd(ADDR_RE, v); chk("re committed", 32'hfffffff3, v);
    rd(ADDR_PE, v); chk("pe restored", PROT_FACTORY, v);
    mrd(0, 16'h1800, v, f); chk("contents kept", 32'h12345678, v);
    // Commit a program enable clear as well
    wr(ADDR_PE, 32'hfffffffd);
    wr(ADDR_TARGET, 32'h00000001);
    wr(ADDR_CTRL, 32'h00000008);
    wait_idle();
    do_reset(1'b0);
    rd(ADDR_PE, v); chk("pe committed", 32'hfffffffd, v);
    rd(ADDR_RE, v); chk("re still committed", 32'hfffffff3, v);
    give_verdict();
  end
endmodule
